// ### rtl/lpi_defines.vh
// constants for the low power idle timing and capability block
`ifndef LPI_DEFINES_VH
`define LPI_DEFINES_VH
`define LPI_CLK_MHZ      125
`define LPI_TS_NS        5000
`define LPI_TQ_US        1750
`define LPI_TR_NS        17200
`define LPI_TW_PHY_NS    13000
`define LPI_DLL_WAIT_S   10
`define LPI_TS_CYC       ((`LPI_TS_NS * `LPI_CLK_MHZ) / 1000)
`define LPI_TQ_CYC       (`LPI_TQ_US * `LPI_CLK_MHZ)
`define LPI_TR_CYC       ((`LPI_TR_NS * `LPI_CLK_MHZ) / 1000)
`define LPI_TW_PHY_CYC   ((`LPI_TW_PHY_NS * `LPI_CLK_MHZ) / 1000)
`define LPI_DLL_WAIT_CYC (`LPI_DLL_WAIT_S * `LPI_CLK_MHZ * 1000000)
`define LPI_ADDR_CTRL    8'h00
`define LPI_ADDR_TWSYS   8'h04
`define LPI_ADDR_DELAY   8'h08
`define LPI_ADDR_STATUS  8'h0C
`define LPI_ADDR_SHRINK  8'h10
`define LPI_ADDR_ECHO    8'h14
`define LPI_CTRL_ADV_EEE 0
`define LPI_CTRL_ADV_DS  1
`define LPI_CTRL_FW_ONLY 2
`define LPI_CTRL_DLL_EN  3
`define LPI_CTRL_TX_RDY  4
`define LPI_CTRL_RX_RDY  5
`define LPI_CTRL_SPD10   6
`define LPI_CTRL_SPD40   7
`define LPI_CTRL_RST     8'h01
`define LPI_TWSYS_RST    32'h000A_000A
`define LPI_DELAY_RST    32'h0000_0000
`define LPI_ST_MISS      4
`endif

// ### rtl/lpi_timing.v
// low power idle timers, wake bookkeeping and capability resolution
// How it works
// - sleep signal held for the sleep interval before transmitters go off
// - quiet interval counted after going silent, before each refresh
// - each refresh burst lasts the refresh interval
// - wake phase ends within the minimum phy wake time
// - transmit system wake time held in a register, in microseconds
// - transmit shrinkage is absolute difference of wake and propagation delay
// - local end advertises low power idle unless fast wake only
// - fast wake is learned from link layer frames only
// - idle supported only when both ends advertised it
// - unsupported idle blocks the client request and all sequencing
// - deep sleep needs both ends to advertise it
// - transmit and receive idle directions run independently
// - resolution reruns on every negotiation start and completion
// - link layer exchange forced on at 10 Gb/s and above
// - received fast wake element proves partner fast wake support
// - fast wake element shows deep sleep only when both advertised
// - fast wake element exchange forced on at 40 Gb/s and above
// - both transmit and receive echo bookkeeping kept here
// - fractional microsecond values round up
// - first wake-time frame requested within the ten second limit
// - changed transmit wake value triggers an echo frame in time
// - changed receive wake value triggers an echo frame in time
// - quiet and refresh alternate until client returns, then wake
// - deferral toward the mac held a delay after the sequencer returns to idle
`timescale 1ns/1ns
`default_nettype none
`include "lpi_defines.vh"
module lpi_timing #(
  parameter [31:0] TQ_CYC   = `LPI_TQ_CYC,
  parameter [31:0] WAIT_CYC = `LPI_DLL_WAIT_CYC
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // auto-negotiation
  input  wire        an_start,
  input  wire        an_done,
  input  wire        link_ok,
  input  wire        lp_adv_eee,
  input  wire        lp_adv_ds,
  output reg         adv_eee,
  output reg         adv_ds,
  // client and rx side
  input  wire        lpi_req,
  input  wire        rx_lpi_in,
  output reg         rx_lpi_ind,
  output reg         defer_mac,
  // phy transmit sequencing
  output wire        tx_sleep,
  output wire        tx_quiet,
  output wire        tx_refresh,
  output wire        tx_wake,
  output reg         wake_done,
  // link layer exchange
  input  wire        fw_tlv_rx,
  input  wire        tlv_rx,
  input  wire [15:0] tlv_rx_tx_tw,
  input  wire [15:0] tlv_rx_rx_tw,
  input  wire        tlv_sent,
  output reg         tlv_req,
  output reg         tlv_ds,
  output reg         eee_ok,
  output reg         ds_ok,
  output reg         fw_ok
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_SLP  = 5'h02;
  localparam [4:0] ST_QT   = 5'h04;
  localparam [4:0] ST_REF  = 5'h08;
  localparam [4:0] ST_WAKE = 5'h10;
  localparam [31:0] TS_CYC = `LPI_TS_CYC;
  localparam [31:0] TR_CYC = `LPI_TR_CYC;
  localparam [31:0] TW_CYC = `LPI_TW_PHY_CYC;
  localparam [31:0] MHZ    = `LPI_CLK_MHZ;

  reg  [7:0]  ctrl_reg;
  reg  [31:0] twsys_reg;
  reg  [31:0] delay_reg;
  reg  [4:0]  st_reg;
  reg  [4:0]  st_next;
  reg  [31:0] cnt_reg;
  reg  [31:0] cnt_next;
  reg  [31:0] dfr_reg;
  reg  [31:0] wait_reg;
  reg         miss_reg;
  reg  [15:0] rem_tx_reg;
  reg  [15:0] rem_rx_reg;
  reg         pair_reg;
  reg  [15:0] shr_ns_reg;
  reg  [15:0] shr_us_reg;
  wire        dll_on;
  wire        pair_now;
  wire        req_ok;
  wire [15:0] wk_ns;
  wire [15:0] pr_ns;
  wire [15:0] diff_ns;
  wire [16:0] up_sum;
  wire [16:0] up_us;
  wire [31:0] dfr_load;
  wire [47:0] dfr_prod;
  wire        pair_rise;
  wire        tx_chg;
  wire        rx_chg;
  wire        tlv_trig;
  wire        miss_clr;

  assign tx_sleep   = st_reg[1];
  assign tx_quiet   = st_reg[2];
  assign tx_refresh = st_reg[3];
  assign tx_wake    = st_reg[4];

  // exchange forced on at 10 Gb/s and up
  // speed forces exchange
  assign dll_on   = ctrl_reg[`LPI_CTRL_DLL_EN] |
                    ctrl_reg[`LPI_CTRL_SPD10] |
                    ctrl_reg[`LPI_CTRL_SPD40];
  assign pair_now = dll_on & ctrl_reg[`LPI_CTRL_TX_RDY] &
                    ctrl_reg[`LPI_CTRL_RX_RDY];
  assign req_ok   = lpi_req & eee_ok;

  assign wk_ns   = delay_reg[15:0];
  assign pr_ns   = delay_reg[31:16];
  assign diff_ns = (wk_ns >= pr_ns) ? (wk_ns - pr_ns) : (pr_ns - wk_ns);
  assign up_sum  = {1'b0, diff_ns} + 17'h003E7;
  // full 17-bit quotient, sums above 16 bits stay correct
  assign up_us   = up_sum / 17'h003E8;
  assign dfr_prod = twsys_reg[15:0] * MHZ;
  assign dfr_load = dfr_prod[31:0];

  // first frame once both ready flags are up
  assign pair_rise = pair_now & ~pair_reg;
  // partner transmit value differs from the echo
  assign tx_chg    = tlv_rx & pair_now & (tlv_rx_tx_tw != rem_tx_reg);
  // partner receive value differs from the echo
  assign rx_chg    = tlv_rx & pair_now & (tlv_rx_rx_tw != rem_rx_reg);
  assign tlv_trig  = pair_rise | tx_chg | rx_chg;
  // write one to the miss bit clears it
  assign miss_clr  = reg_wr & (reg_addr == `LPI_ADDR_STATUS) &
                     reg_wdata[`LPI_ST_MISS];

  // transmit sequencer
  // quiet refresh alternation
  always @* begin
    st_next  = st_reg;
    cnt_next = (cnt_reg != 32'h0) ? cnt_reg - 32'h1 : 32'h0;
    case (st_reg)
      ST_IDLE: begin
        // load the sleep interval on entry
        if (req_ok) begin
          st_next  = ST_SLP;
          cnt_next = TS_CYC;
        end
      end
      ST_SLP: begin
        if (!req_ok) begin
          st_next  = ST_WAKE;
          cnt_next = TW_CYC;
        end else if (cnt_reg <= 32'h1) begin
          st_next  = ST_QT;
          cnt_next = TQ_CYC;
        end
      end
      ST_QT: begin
        if (!req_ok) begin
          st_next  = ST_WAKE;
          cnt_next = TW_CYC;
        end else if (cnt_reg <= 32'h1) begin
          st_next  = ST_REF;
          cnt_next = TR_CYC;
        end
      end
      ST_REF: begin
        if (!req_ok) begin
          st_next  = ST_WAKE;
          cnt_next = TW_CYC;
        end else if (cnt_reg <= 32'h1) begin
          st_next  = ST_QT;
          cnt_next = TQ_CYC;
        end
      end
      ST_WAKE: begin
        if (cnt_reg <= 32'h1) begin
          st_next = ST_IDLE;
        end
      end
      default: begin
        st_next  = ST_IDLE;
        cnt_next = 32'h0;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      st_reg    <= ST_IDLE;
      cnt_reg   <= 32'h0;
      wake_done <= 1'b0;
    end else begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      // pulse shows with the first idle cycle
      wake_done <= tx_wake & (st_next == ST_IDLE);
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      defer_mac <= 1'b0;
      dfr_reg   <= 32'h0;
    end else if (req_ok || st_reg != ST_IDLE) begin
      defer_mac <= 1'b1;
      // reload while busy so the count starts at idle
      dfr_reg   <= dfr_load;
    end else if (dfr_reg != 32'h0) begin
      defer_mac <= 1'b1;
      dfr_reg   <= dfr_reg - 32'h1;
    end else begin
      defer_mac <= 1'b0;
    end
  end

  // capability resolution
  always @(posedge clk_sys) begin
    if (rst) begin
      eee_ok     <= 1'b0;
      ds_ok      <= 1'b0;
      fw_ok      <= 1'b0;
      rx_lpi_ind <= 1'b0;
      adv_eee    <= 1'b0;
      adv_ds     <= 1'b0;
      tlv_ds     <= 1'b0;
    end else begin
      adv_eee <= ctrl_reg[`LPI_CTRL_ADV_EEE] &
                 ~ctrl_reg[`LPI_CTRL_FW_ONLY];
      adv_ds  <= ctrl_reg[`LPI_CTRL_ADV_DS] &
                 ~ctrl_reg[`LPI_CTRL_FW_ONLY];
      tlv_ds  <= ds_ok;
      rx_lpi_ind <= rx_lpi_in & eee_ok;
      // rerun on negotiation
      // clears win over a coincident an_done
      if (!link_ok || an_start) begin
        eee_ok <= 1'b0;
        ds_ok  <= 1'b0;
        fw_ok  <= 1'b0;
      end else begin
        if (an_done) begin
          eee_ok <= adv_eee & lp_adv_eee;
          ds_ok  <= adv_eee & lp_adv_eee & adv_ds & lp_adv_ds;
        end
        if (fw_tlv_rx && dll_on) begin
          fw_ok <= 1'b1;
        end
      end
    end
  end

  // link layer exchange deadlines
  always @(posedge clk_sys) begin
    if (rst) begin
      pair_reg   <= 1'b0;
      tlv_req    <= 1'b0;
      wait_reg   <= 32'h0;
      miss_reg   <= 1'b0;
      rem_tx_reg <= 16'h0000;
      rem_rx_reg <= 16'h0000;
    end else begin
      pair_reg <= pair_now;
      if (tlv_rx && pair_now) begin
        rem_tx_reg <= tlv_rx_tx_tw;
        rem_rx_reg <= tlv_rx_rx_tw;
      end
      if (tlv_trig) begin
        tlv_req  <= 1'b1;
        wait_reg <= WAIT_CYC;
      end else if (tlv_sent || !pair_now) begin
        tlv_req  <= 1'b0;
        wait_reg <= 32'h0;
      // count down only while a frame is owed
      end else if (tlv_req && wait_reg != 32'h0) begin
        wait_reg <= wait_reg - 32'h1;
      end
      // miss sticky; a new miss wins over clear
      if (tlv_req && pair_now && !tlv_sent && wait_reg == 32'h1) begin
        miss_reg <= 1'b1;
      end else if (miss_clr) begin
        miss_reg <= 1'b0;
      end
    end
  end

  // shrinkage results
  always @(posedge clk_sys) begin
    if (rst) begin
      shr_ns_reg <= 16'h0000;
      shr_us_reg <= 16'h0000;
    end else begin
      shr_ns_reg <= diff_ns;
      shr_us_reg <= up_us[15:0];
    end
  end

  // register writes
  // tx wake time storage
  always @(posedge clk_sys) begin
    if (rst) begin
      ctrl_reg  <= `LPI_CTRL_RST;
      twsys_reg <= `LPI_TWSYS_RST;
      delay_reg <= `LPI_DELAY_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `LPI_ADDR_CTRL:  ctrl_reg  <= reg_wdata[7:0];
        `LPI_ADDR_TWSYS: twsys_reg <= reg_wdata;
        `LPI_ADDR_DELAY: delay_reg <= reg_wdata;
        // status, shrink and echo are read only here
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // register reads, one cycle later
  always @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `LPI_ADDR_CTRL:   reg_rdata <= {24'h0, ctrl_reg};
        `LPI_ADDR_TWSYS:  reg_rdata <= twsys_reg;
        `LPI_ADDR_DELAY:  reg_rdata <= delay_reg;
        // flags low, one-hot state above
        `LPI_ADDR_STATUS: reg_rdata <= {22'h0, st_reg, miss_reg,
                                        tlv_req, fw_ok, ds_ok, eee_ok};
        `LPI_ADDR_SHRINK: reg_rdata <= {shr_us_reg, shr_ns_reg};
        `LPI_ADDR_ECHO:   reg_rdata <= {rem_rx_reg, rem_tx_reg};
        default:          reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end
endmodule
`default_nettype wire

// ### tb/lpi_asserts.sv
// concurrent checks on the low power idle block ports
`timescale 1ns/1ns
`default_nettype none
module lpi_asserts #(
  parameter [31:0] TQ_CYC = 32'h32
) (
  input wire logic clk_sys, rst, an_start, an_done, link_ok,
  input wire logic lp_adv_eee, lp_adv_ds, adv_eee, adv_ds, lpi_req,
  input wire logic defer_mac, tx_sleep, tx_quiet, tx_refresh, tx_wake,
  input wire logic wake_done, fw_tlv_rx, tlv_sent, tlv_req, tlv_ds,
  input wire logic eee_ok, ds_ok, fw_ok
);
  logic [3:0] st;
  logic [3:0] st_q;
  int         run;
  assign st = {tx_sleep, tx_quiet, tx_refresh, tx_wake};
  // length of the state just left
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= 4'h0;
      run  <= 0;
    end else begin
      st_q <= st;
      run  <= (st != st_q) ? 1 : run + 1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_wake_end;
    tx_wake ##1 !tx_wake;
  endsequence
  property p_sleep; st_q == 4'h8 && tx_quiet |-> run == 625; endproperty
  property p_quiet; st_q == 4'h4 && tx_refresh |-> run == TQ_CYC; endproperty
  property p_refr; st_q == 4'h2 && tx_quiet |-> run == 2150; endproperty
  property p_wake; st_q == 4'h1 && st == 4'h0 |-> run == 1625; endproperty
  property p_done; s_wake_end |-> wake_done; endproperty
  property p_start; $rose(tx_sleep) |-> $past(lpi_req && eee_ok); endproperty
  property p_exit;
    (tx_sleep || tx_quiet || tx_refresh) && !lpi_req |=> tx_wake;
  endproperty
  property p_defer; (|st) |-> defer_mac; endproperty
  property p_eee;
    $rose(eee_ok) |-> $past(an_done && link_ok && lp_adv_eee && adv_eee);
  endproperty
  property p_ds; $rose(ds_ok) |-> $past(an_done && lp_adv_ds && adv_ds);
  endproperty
  property p_clr; !link_ok || an_start |=> !(eee_ok || ds_ok || fw_ok);
  endproperty
  property p_fw; $rose(fw_ok) |-> $past(fw_tlv_rx); endproperty
  property p_tds; ds_ok |=> tlv_ds; endproperty
  property p_sent; tlv_sent |=> !tlv_req; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep len");
  a_quiet: assert property (p_quiet) else $error("quiet len");
  a_refr: assert property (p_refr) else $error("refresh len");
  a_wake: assert property (p_wake) else $error("wake len");
  a_done: assert property (p_done) else $error("wake done");
  a_start: assert property (p_start) else $error("bad start");
  a_exit: assert property (p_exit) else $error("no wake");
  a_defer: assert property (p_defer) else $error("no defer");
  a_eee: assert property (p_eee) else $error("eee set");
  a_ds: assert property (p_ds) else $error("ds set");
  a_clr: assert property (p_clr) else $error("flags kept");
  a_fw: assert property (p_fw) else $error("fw set");
  a_tds: assert property (p_tds) else $error("elem ds");
  a_sent: assert property (p_sent) else $error("req kept");
endmodule
`default_nettype wire

// ### tb/lpi_partner.sv
// far end model answering wake-time frame requests
`timescale 1ns/1ns
`default_nettype none
module lpi_partner (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // frame request and stall
  input  wire logic tlv_req,
  input  wire logic hold,
  output var  logic tlv_sent
);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tlv_sent <= 1'b0;
    end else begin
      tlv_sent <= tlv_req && !tlv_sent && !hold;
    end
  end
endmodule
`default_nettype wire

// ### tb/lpi_timing_test.sv
// self-checking bench for the low power idle block
`timescale 1ns/1ns
`default_nettype none
module lpi_timing_test;
  localparam int TQ = 50;
  localparam int WT = 200;
  logic        clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        an_start = 1'b0, an_done = 1'b0, link_ok = 1'b1, hold = 1'b1;
  logic        lp_adv_eee = 1'b0, lp_adv_ds = 1'b0, lpi_req = 1'b0;
  logic        rx_lpi_in = 1'b0, fw_tlv_rx = 1'b0, tlv_rx = 1'b0;
  logic [7:0]  reg_addr = 8'h00, c;
  logic [15:0] tx_tw = 16'h0, rx_tw = 16'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_v, r, e;
  logic [31:0] seed = 32'h6F8C;
  logic        adv_eee, adv_ds, rx_lpi_ind, defer_mac, tx_sleep, tx_quiet;
  logic        tx_refresh, tx_wake, wake_done, tlv_sent, tlv_req, tlv_ds;
  logic        eee_ok, ds_ok, fw_ok;
  logic [3:0]  st;
  int          failures = 0, n_compared = 0, cyc = 0;
  assign st = {tx_sleep, tx_quiet, tx_refresh, tx_wake};
  always #4 clk_sys = ~clk_sys;
  lpi_timing #(.TQ_CYC(TQ), .WAIT_CYC(WT)) i_lpi_timing (
    .clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .an_start, .an_done, .link_ok, .lp_adv_eee, .lp_adv_ds, .adv_eee,
    .adv_ds, .lpi_req, .rx_lpi_in, .rx_lpi_ind, .defer_mac, .tx_sleep,
    .tx_quiet, .tx_refresh, .tx_wake, .wake_done, .fw_tlv_rx, .tlv_rx,
    .tlv_rx_tx_tw(tx_tw), .tlv_rx_rx_tw(rx_tw), .tlv_sent, .tlv_req,
    .tlv_ds, .eee_ok, .ds_ok, .fw_ok);
  lpi_partner i_lpi_partner (.clk_sys, .rst, .tlv_req, .hold, .tlv_sent);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] shr(logic [31:0] d);
    logic [15:0] a;
    logic [16:0] u;
    a = (d[15:0] > d[31:16]) ? d[15:0] - d[31:16] : d[31:16] - d[15:0];
    u = ({1'b0, a} + 17'h003E7) / 17'h003E8;
    return {u[15:0], a};
  endfunction
  task automatic t(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic cmp(logic [31:0] g, logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, g, x);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    t(1);
    reg_wr    <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [7:0] a);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    t(1);
    rd_v = reg_rdata;
    reg_rd   <= 1'b0;
    #1;
  endtask
  task automatic neg(logic [7:0] k, logic le, logic ld);
    wr(8'h00, {24'h0, k});
    lp_adv_eee <= le;
    lp_adv_ds  <= ld;
    an_start   <= 1'b1;
    t(1);
    an_start   <= 1'b0;
    an_done    <= 1'b1;
    t(1);
    an_done    <= 1'b0;
    t(1);
  endtask
  task automatic dur(int b, int x);
    int n;
    n = 0;
    while (st[b] !== 1'b1) t(1);
    while (st[b] === 1'b1) begin
      n++;
      t(1);
    end
    cmp(n, x);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    t(12);
    rst <= 1'b0;
    t(1);
    rd(8'h00);
    cmp(rd_v, 32'h01);
    rd(8'h04);
    cmp(rd_v, 32'h000A_000A);
    rd(8'h0C);
    cmp(rd_v, 32'h20);
    rd(8'h20);
    cmp(rd_v, 32'h0);
    $display("reset values done");
    for (int i = 0; i < 10; i++) begin
      r = rnd();
      c = {5'h0, r[2], r[1] & r[0], r[0]};
      neg(c, r[3], r[3] & r[4]);
      rd(8'h0C);
      e = {30'h0, c[1] & r[4] & r[3] & ~c[2], c[0] & r[3] & ~c[2]};
      cmp(rd_v & 32'h3, e);
      cmp({adv_ds, adv_eee}, {c[1] & ~c[2], c[0] & ~c[2]});
    end
    neg(8'h03, 1'b1, 1'b1);
    cmp({ds_ok, eee_ok}, 32'h3);
    cmp(tlv_ds, 32'h1);
    link_ok <= 1'b0;
    t(1);
    link_ok <= 1'b1;
    cmp({ds_ok, eee_ok}, 32'h0);
    rx_lpi_in <= 1'b1;
    lpi_req   <= 1'b1;
    t(20);
    cmp({rx_lpi_ind, st}, 32'h0);
    $display("resolution done");
    lpi_req <= 1'b0;
    neg(8'h01, 1'b1, 1'b0);
    wr(8'h04, 32'h000A_0002);
    lpi_req <= 1'b1;
    dur(3, 625);
    cmp(rx_lpi_ind, 32'h1);
    dur(2, TQ);
    dur(1, 2150);
    t(10);
    lpi_req   <= 1'b0;
    rx_lpi_in <= 1'b0;
    dur(0, 1625);
    cmp(wake_done, 32'h1);
    t(240);
    cmp(defer_mac, 32'h1);
    t(20);
    cmp(defer_mac, 32'h0);
    $display("sequencer done");
    wr(8'h00, 32'h39);
    t(2);
    cmp(tlv_req, 32'h1);
    t(WT + 5);
    rd(8'h0C);
    cmp(rd_v & 32'h18, 32'h18);
    hold <= 1'b0;
    t(3);
    cmp(tlv_req, 32'h0);
    wr(8'h0C, 32'h10);
    rd(8'h0C);
    cmp(rd_v & 32'h18, 32'h0);
    r = rnd();
    for (int i = 0; i < 4; i++) begin
      hold <= 1'b1;
      if (i == 2) r[31:16] = r[31:16] + 16'h0001;
      if (i == 3) r[15:0] = r[15:0] + 16'h0001;
      tx_tw  <= r[15:0];
      rx_tw  <= r[31:16];
      tlv_rx <= 1'b1;
      t(1);
      tlv_rx <= 1'b0;
      t(1);
      cmp(tlv_req, i != 1);
      rd(8'h14);
      cmp(rd_v, r);
      hold <= 1'b0;
      t(4);
    end
    for (int i = 0; i < 2; i++) begin
      wr(8'h00, i ? 32'h81 : 32'h01);
      fw_tlv_rx <= 1'b1;
      t(1);
      fw_tlv_rx <= 1'b0;
      t(1);
      cmp(fw_ok, i);
    end
    $display("exchange done");
    for (int i = 0; i < 4; i++) begin
      r = (i == 0) ? 32'h03E8_07D0 : rnd();
      wr(8'h08, r);
      t(2);
      rd(8'h10);
      cmp(rd_v, shr(r));
    end
    $display("shrinkage done");
    tally_and_finish();
  end
endmodule
bind lpi_timing lpi_asserts #(.TQ_CYC(TQ_CYC)) i_lpi_asserts (
  .clk_sys, .rst, .an_start, .an_done, .link_ok, .lp_adv_eee, .lp_adv_ds,
  .adv_eee, .adv_ds, .lpi_req, .defer_mac, .tx_sleep, .tx_quiet,
  .tx_refresh, .tx_wake, .wake_done, .fw_tlv_rx, .tlv_sent, .tlv_req,
  .tlv_ds, .eee_ok, .ds_ok, .fw_ok);
`default_nettype wire
